// >>> core/atc_cycle_gen.sv
`timescale 1ns/1ps
`default_nettype none

module atc_cycle_gen #(
  parameter int CLOCKS = atc_pkg::MACHINE_CYCLE_CLOCKS,
  parameter int PHASE  = atc_pkg::SAMPLE_PHASE
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      strobe
);

  localparam int CW = $clog2(CLOCKS);
  localparam logic [CW-1:0] LAST  = CW'(CLOCKS - 1);
  localparam logic [CW-1:0] PH    = CW'(PHASE);

  logic [CW-1:0] phase_reg;
  logic [CW-1:0] phase_next;
  logic          strobe_next;

  // Phase counter wraps once per machine cycle; the strobe marks one fixed phase.
  always_comb
  begin
    phase_next  = (phase_reg == LAST) ? '0 : phase_reg + CW'(1);
    strobe_next = (phase_next == PH);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= '0;
      strobe    <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      strobe    <= strobe_next;
    end
  end

endmodule
`default_nettype wire

// >>> core/atc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module atc_sync2 #(
  parameter int WIDTH = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // Two stages; only the second stage is ever read outside.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// >>> core/atc_timer.sv
// Contract
// - In counter mode the count pin is sampled once per machine cycle at one fixed phase.
// - With pin-qualify set, counting runs only while request pin A is high and run is set.
// - With pin-qualify clear, counting runs whenever run is set, whatever pin A does.
// - Count-source set counts count-pin falling (high-to-low) transitions, clear counts oscillator over twelve.
// - The counter advances while run is set and holds while it is clear.
// - The 16-bit count increments per tick and on overflow loads the unchanged reload pair.
// - Overflow sets the overflow flag, which requests an interrupt when enabled.
// - The overflow flag clears when the timer interrupt is vectored, and on reset.
// - Control holds edge flag A at bit 3, trigger A at 2, edge flag B at 1, trigger B at 0.
`timescale 1ns/1ps
`default_nettype none

module atc_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_input_pin,
  input  wire logic        ext_request_pin_a,
  input  wire logic        ext_request_pin_b,
  input  wire logic        timer_vector_ack,
  input  wire logic        ext_a_vector_ack,
  input  wire logic        ext_b_vector_ack,
  output logic             timer_request,
  output logic             ext_request_a,
  output logic             ext_request_b,
  output logic             irq
);

  logic [2:0]  pins_s;
  logic        sample_strobe;
  logic        pin_count_s;
  logic        pin_a_s;
  logic        pin_b_s;

  logic [7:0]  control_reg;
  logic [7:0]  control_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  reload_low_reg;
  logic [7:0]  reload_low_next;
  logic [7:0]  reload_high_reg;
  logic [7:0]  reload_high_next;
  logic [2:0]  int_status_reg;
  logic [2:0]  int_status_next;
  logic [2:0]  int_mask_reg;
  logic [2:0]  int_mask_next;
  logic        count_sample_reg;
  logic        count_sample_next;
  logic        pin_a_prev_reg;
  logic        pin_b_prev_reg;

  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;
  logic        timer_request_next;
  logic        ext_request_a_next;
  logic        ext_request_b_next;
  logic        irq_next;

  logic [7:0]  index;
  logic        wr_go;
  logic        lane0;
  logic        mapped;
  logic        wr_control;
  logic        wr_count_low;
  logic        wr_count_high;
  logic        wr_reload_low;
  logic        wr_reload_high;
  logic        enable;
  logic        count_edge;
  logic        tick;
  logic        overflow_event;
  logic        fall_a;
  logic        fall_b;
  logic        edge_a_event;
  logic        edge_b_event;
  logic [2:0]  events;

  // Pins come from outside the clock domain, so each passes two flip-flops first.
  atc_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({count_input_pin, ext_request_pin_a, ext_request_pin_b}),
    .q       (pins_s)
  );

  // Machine cycle timing; the oscillator is pclk itself.
  atc_cycle_gen #(
    .CLOCKS (atc_pkg::MACHINE_CYCLE_CLOCKS),
    .PHASE  (atc_pkg::SAMPLE_PHASE)
  ) u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .strobe  (sample_strobe)
  );

  assign pin_count_s = pins_s[2];
  assign pin_a_s     = pins_s[1];
  assign pin_b_s     = pins_s[0];

  // Bus decode; a write lands only in the access cycle with pready high.
  always_comb
  begin
    index          = atc_pkg::atc_index(paddr);
    wr_go          = psel & penable & pwrite & pready;
    lane0          = pstrb[0];
    mapped         = (index == atc_pkg::IDX_CONTROL) | (index == atc_pkg::IDX_COUNT_LOW) |
                     (index == atc_pkg::IDX_COUNT_HIGH) | (index == atc_pkg::IDX_RELOAD_LOW) |
                     (index == atc_pkg::IDX_RELOAD_HIGH) | (index == atc_pkg::IDX_INT_STATUS) |
                     (index == atc_pkg::IDX_INT_MASK);
    wr_control     = wr_go & lane0 & (index == atc_pkg::IDX_CONTROL);
    wr_count_low   = wr_go & lane0 & (index == atc_pkg::IDX_COUNT_LOW);
    wr_count_high  = wr_go & lane0 & (index == atc_pkg::IDX_COUNT_HIGH);
    wr_reload_low  = wr_go & lane0 & (index == atc_pkg::IDX_RELOAD_LOW);
    wr_reload_high = wr_go & lane0 & (index == atc_pkg::IDX_RELOAD_HIGH);
  end

  // Tick and event detection. The count pin is looked at only on the strobe, so a pulse
  // shorter than a machine cycle can be missed; that is the price of cycle sampling.
  always_comb
  begin
    count_sample_next = sample_strobe ? pin_count_s : count_sample_reg;
    count_edge        = sample_strobe & count_sample_reg & ~pin_count_s;
    enable            = control_reg[atc_pkg::BIT_RUN] &
                        (~control_reg[atc_pkg::BIT_PIN_QUALIFY] | pin_a_s);
    tick              = enable & (control_reg[atc_pkg::BIT_COUNT_SOURCE] ?
                                  count_edge : sample_strobe);
    overflow_event    = tick & (count_reg == 16'hffff);
    fall_a            = pin_a_prev_reg & ~pin_a_s;
    fall_b            = pin_b_prev_reg & ~pin_b_s;
    edge_a_event      = fall_a & control_reg[atc_pkg::BIT_A_TRIGGER];
    edge_b_event      = fall_b & control_reg[atc_pkg::BIT_B_TRIGGER];
    events            = 3'h0;
    events[atc_pkg::IRQ_OVERFLOW] = overflow_event;
    events[atc_pkg::IRQ_A_EDGE]   = edge_a_event;
    events[atc_pkg::IRQ_B_EDGE]   = edge_b_event;
  end

  // Counter and reload pair. A software byte write wins over a tick in the same cycle.
  always_comb
  begin
    count_next       = count_reg;
    reload_low_next  = reload_low_reg;
    reload_high_next = reload_high_reg;
    if (overflow_event)
      count_next = {reload_high_reg, reload_low_reg};
    else if (tick)
      count_next = count_reg + 16'h0001;
    if (wr_count_low)
      count_next[7:0] = pwdata[7:0];
    if (wr_count_high)
      count_next[15:8] = pwdata[7:0];
    if (wr_reload_low)
      reload_low_next = pwdata[7:0];
    if (wr_reload_high)
      reload_high_next = pwdata[7:0];
  end

  // Control register: clears are applied first so that a hardware set in the same cycle wins.
  always_comb
  begin
    control_next = control_reg;
    if (wr_control)
      control_next = pwdata[7:0];
    if (timer_vector_ack)
      control_next[atc_pkg::BIT_OVERFLOW] = 1'b0;
    if (ext_a_vector_ack & control_reg[atc_pkg::BIT_A_TRIGGER])
      control_next[atc_pkg::BIT_A_EDGE_FLAG] = 1'b0;
    if (ext_b_vector_ack & control_reg[atc_pkg::BIT_B_TRIGGER])
      control_next[atc_pkg::BIT_B_EDGE_FLAG] = 1'b0;
    if (overflow_event)
      control_next[atc_pkg::BIT_OVERFLOW] = 1'b1;
    if (edge_a_event)
      control_next[atc_pkg::BIT_A_EDGE_FLAG] = 1'b1;
    if (edge_b_event)
      control_next[atc_pkg::BIT_B_EDGE_FLAG] = 1'b1;
  end

  // Sticky status, write one to clear, set wins; mask gates the single interrupt line.
  always_comb
  begin
    int_status_next = int_status_reg;
    int_mask_next   = int_mask_reg;
    if (wr_go & lane0 & (index == atc_pkg::IDX_INT_STATUS))
      int_status_next = int_status_reg & ~pwdata[2:0];
    if (wr_go & lane0 & (index == atc_pkg::IDX_INT_MASK))
      int_mask_next = pwdata[2:0];
    int_status_next = int_status_next | events;
    irq_next        = |(int_status_next & int_mask_next);
    // Level-triggered requests follow the active-low pin directly.
    timer_request_next = control_next[atc_pkg::BIT_OVERFLOW];
    ext_request_a_next = control_next[atc_pkg::BIT_A_TRIGGER] ?
                         control_next[atc_pkg::BIT_A_EDGE_FLAG] : ~pin_a_s;
    ext_request_b_next = control_next[atc_pkg::BIT_B_TRIGGER] ?
                         control_next[atc_pkg::BIT_B_EDGE_FLAG] : ~pin_b_s;
  end

  // APB answer: data captured in the setup cycle, pready high for the whole access cycle.
  always_comb
  begin
    pready_next  = psel & ~penable;
    pslverr_next = psel & ~penable & ~mapped;
    prdata_next  = 32'h0000_0000;
    if (psel & ~penable & ~pwrite)
    begin
      unique case (index)
        atc_pkg::IDX_CONTROL:     prdata_next[7:0] = control_reg;
        atc_pkg::IDX_COUNT_LOW:   prdata_next[7:0] = count_reg[7:0];
        atc_pkg::IDX_COUNT_HIGH:  prdata_next[7:0] = count_reg[15:8];
        atc_pkg::IDX_RELOAD_LOW:  prdata_next[7:0] = reload_low_reg;
        atc_pkg::IDX_RELOAD_HIGH: prdata_next[7:0] = reload_high_reg;
        atc_pkg::IDX_INT_STATUS:  prdata_next[2:0] = int_status_reg;
        atc_pkg::IDX_INT_MASK:    prdata_next[2:0] = int_mask_reg;
        default:                  prdata_next      = 32'h0000_0000;
      endcase
    end
  end

  // All state registers; reset clears every flag, the overflow flag included.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_reg      <= atc_pkg::RST_CONTROL;
      count_reg        <= {atc_pkg::RST_BYTE, atc_pkg::RST_BYTE};
      reload_low_reg   <= atc_pkg::RST_BYTE;
      reload_high_reg  <= atc_pkg::RST_BYTE;
      int_status_reg   <= atc_pkg::RST_IRQ;
      int_mask_reg     <= atc_pkg::RST_IRQ;
      count_sample_reg <= 1'b0;
      pin_a_prev_reg   <= 1'b0;
      pin_b_prev_reg   <= 1'b0;
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      timer_request    <= 1'b0;
      ext_request_a    <= 1'b0;
      ext_request_b    <= 1'b0;
      irq              <= 1'b0;
    end
    else
    begin
      control_reg      <= control_next;
      count_reg        <= count_next;
      reload_low_reg   <= reload_low_next;
      reload_high_reg  <= reload_high_next;
      int_status_reg   <= int_status_next;
      int_mask_reg     <= int_mask_next;
      count_sample_reg <= count_sample_next;
      pin_a_prev_reg   <= pin_a_s;
      pin_b_prev_reg   <= pin_b_s;
      prdata           <= prdata_next;
      pready           <= pready_next;
      pslverr          <= pslverr_next;
      timer_request    <= timer_request_next;
      ext_request_a    <= ext_request_a_next;
      ext_request_b    <= ext_request_b_next;
      irq              <= irq_next;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sample_period: assert property (sample_strobe |-> ##12 sample_strobe)
    else $error("count pin sample strobe is not once per machine cycle");

  a_stop_holds: assert property (
    (!control_reg[atc_pkg::BIT_RUN] && !wr_count_low && !wr_count_high) |=> $stable(count_reg)
  ) else $error("counter moved while run bit clear");

  a_qualify_blocks: assert property (
    (control_reg[atc_pkg::BIT_PIN_QUALIFY] && !pin_a_s && !wr_count_low && !wr_count_high)
    |=> $stable(count_reg)
  ) else $error("counter moved while qualify pin low");

  a_free_run_tick: assert property (
    (control_reg[atc_pkg::BIT_RUN] && !control_reg[atc_pkg::BIT_PIN_QUALIFY] &&
     !control_reg[atc_pkg::BIT_COUNT_SOURCE] && sample_strobe && count_reg != 16'hffff &&
     !wr_count_low && !wr_count_high) |=> count_reg == $past(count_reg) + 16'h0001
  ) else $error("timer mode failed to increment on machine cycle");

  a_source_edge: assert property (
    (control_reg[atc_pkg::BIT_COUNT_SOURCE] && !count_edge && !wr_count_low && !wr_count_high)
    |=> $stable(count_reg)
  ) else $error("counter mode moved without a pin transition");

  a_reload_load: assert property (
    (overflow_event && !wr_count_low && !wr_count_high)
    |=> count_reg == {$past(reload_high_reg), $past(reload_low_reg)}
  ) else $error("overflow did not load the reload pair");

  a_reload_kept: assert property (
    (!wr_reload_low && !wr_reload_high) |=> $stable({reload_high_reg, reload_low_reg})
  ) else $error("reload pair changed without a write");

  // The request is registered from the same next value as the flag, so both rise together;
  // a vector ack one cycle later may legally drop them again.
  a_overflow_flag: assert property (
    overflow_event |=> control_reg[atc_pkg::BIT_OVERFLOW] && timer_request
  ) else $error("overflow flag or request not raised");

  a_vector_clear: assert property (
    (timer_vector_ack && !overflow_event && !wr_control) |=> !control_reg[atc_pkg::BIT_OVERFLOW]
  ) else $error("overflow flag not cleared on vector");

  a_edge_flag_a: assert property (
    edge_a_event |=> control_reg[atc_pkg::BIT_A_EDGE_FLAG] && int_status_reg[atc_pkg::IRQ_A_EDGE]
  ) else $error("falling edge on request A not flagged");

  c_overflow: cover property (overflow_event ##1 timer_vector_ack);
  c_counter_mode: cover property (control_reg[atc_pkg::BIT_COUNT_SOURCE] && tick);
  c_edge_b: cover property (edge_b_event ##[1:4] irq);

endmodule
`default_nettype wire

// >>> shared/atc_pkg.sv
`default_nettype none

package atc_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0] IDX_CONTROL     = 8'h88;
  localparam logic [7:0] IDX_COUNT_LOW   = 8'h8a;
  localparam logic [7:0] IDX_RELOAD_LOW  = 8'h8b;
  localparam logic [7:0] IDX_COUNT_HIGH  = 8'h8c;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'h8d;
  localparam logic [7:0] IDX_INT_STATUS  = 8'h90;
  localparam logic [7:0] IDX_INT_MASK    = 8'h91;

  // Field positions in the timer control register.
  localparam int BIT_PIN_QUALIFY   = 7;
  localparam int BIT_COUNT_SOURCE  = 6;
  localparam int BIT_OVERFLOW      = 5;
  localparam int BIT_RUN           = 4;
  localparam int BIT_A_EDGE_FLAG   = 3;
  localparam int BIT_A_TRIGGER     = 2;
  localparam int BIT_B_EDGE_FLAG   = 1;
  localparam int BIT_B_TRIGGER     = 0;

  // Field positions in the interrupt status and mask registers.
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_A_EDGE   = 1;
  localparam int IRQ_B_EDGE   = 2;
  localparam int IRQ_BITS     = 3;

  // Reset values.
  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [2:0]  RST_IRQ     = 3'h0;

  // Machine cycle: oscillator clocks per cycle and the phase of the count pin sample.
  localparam int MACHINE_CYCLE_CLOCKS = 12;
  localparam int SAMPLE_PHASE         = 6;

  // Word index taken from an APB byte address.
  function automatic logic [7:0] atc_index(input logic [11:0] addr);
    atc_index = addr[9:2];
  endfunction

endpackage

`default_nettype wire

// >>> sim/test_autoreload_timer_counter16.sv
`timescale 1ns/1ps
`default_nettype none

module test_autoreload_timer_counter16;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cnt_pin;
  logic        pin_a;
  logic        pin_b;
  logic        t_ack;
  logic        a_ack;
  logic        b_ack;
  logic        timer_request;
  logic        req_a;
  logic        req_b;
  logic        irq;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0]  regs [7];
  integer      seed;
  int          errors;
  int          n_compared;

  atc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_input_pin(cnt_pin),
    .ext_request_pin_a(pin_a), .ext_request_pin_b(pin_b), .timer_vector_ack(t_ack),
    .ext_a_vector_ack(a_ack), .ext_b_vector_ack(b_ack), .timer_request(timer_request),
    .ext_request_a(req_a), .ext_request_b(req_b), .irq(irq));

  // Free-running 100 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      errors++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run;
    $display("Compared %0d values, %0d mismatches", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; the expected answer is queued for the monitor, then an idle cycle.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] s, input logic [31:0] want, input logic err);
    int i;
    exp_q.push_back({~wr, err, want});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      errors++;
      $display("Error at %0t ns: no bus answer", $time);
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    xfer(1'b1, idx, {24'h0, v}, 4'hf, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] v);
    xfer(1'b0, idx, 32'h0, 4'hf, {24'h0, v}, 1'b0);
  endtask

  // Each completed transfer takes the oldest note; error flag always, data on reads.
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff;
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33])
        chk(prdata, e[31:0]);
    end
  end

  // Loads 0xffff with reload 0x5a and a random low byte, runs with the given control and watches for overflow.
  task automatic ovf(input logic [7:0] ctrl, input logic pa, input logic pulse,
                     input logic want);
    logic [7:0] rl;
    logic [7:0] stop;
    logic       seen;
    int         i;
    rl = 8'($random(seed));
    seen = 1'b0;
    pin_a <= pa;
    wr(atc_pkg::IDX_RELOAD_LOW, rl);
    wr(atc_pkg::IDX_RELOAD_HIGH, 8'h5a);
    wr(atc_pkg::IDX_COUNT_LOW, 8'hff);
    wr(atc_pkg::IDX_COUNT_HIGH, 8'hff);
    wr(atc_pkg::IDX_CONTROL, ctrl);
    for (i = 0; i < 90 && !seen; i++)
    begin
      if (pulse && i == 5)
        cnt_pin <= 1'b1;
      if (pulse && i == 30)
        cnt_pin <= 1'b0;
      @(posedge pclk);
      seen = (timer_request === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, want});
    if (seen)
      chk({31'h0, irq}, 32'h1);
    // Stopping keeps the flag so it can be read back; the next tick is a full cycle away.
    stop = (ctrl & 8'hef) | {2'b00, seen, 5'h0};
    wr(atc_pkg::IDX_CONTROL, stop);
    rd(atc_pkg::IDX_CONTROL, stop);
    rd(atc_pkg::IDX_COUNT_LOW, seen ? rl : 8'hff);
    rd(atc_pkg::IDX_COUNT_HIGH, seen ? 8'h5a : 8'hff);
    rd(atc_pkg::IDX_RELOAD_LOW, rl);
    rd(atc_pkg::IDX_RELOAD_HIGH, 8'h5a);
    t_ack <= 1'b1;
    @(posedge pclk);
    t_ack <= 1'b0;
    idle(3);
    chk({31'h0, timer_request}, 32'h0);
    rd(atc_pkg::IDX_CONTROL, ctrl & 8'hcf);
    rd(atc_pkg::IDX_INT_STATUS, {7'h0, seen});
    wr(atc_pkg::IDX_INT_STATUS, 8'h01);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    $display("Overflow test with control %h done", ctrl);
  endtask

  task automatic pin(input int ch, input logic v);
    if (ch == 0)
      pin_a <= v;
    else
      pin_b <= v;
  endtask

  task automatic ack(input int ch, input logic v);
    if (ch == 0)
      a_ack <= v;
    else
      b_ack <= v;
  endtask

  function automatic logic [31:0] req(input int ch);
    return {31'h0, (ch == 0) ? req_a : req_b};
  endfunction

  // Edge mode sets and acknowledges the flag; level mode follows the pin with no flag.
  task automatic edges(input int ch);
    logic [7:0] trig;
    logic [7:0] flag;
    trig = (ch == 0) ? 8'h04 : 8'h01;
    flag = (ch == 0) ? 8'h08 : 8'h02;
    wr(atc_pkg::IDX_CONTROL, trig);
    pin(ch, 1'b1);
    idle(6);
    chk(req(ch), 32'h0);
    pin(ch, 1'b0);
    idle(6);
    chk(req(ch), 32'h1);
    rd(atc_pkg::IDX_CONTROL, trig | flag);
    chk({31'h0, irq}, 32'h1);
    ack(ch, 1'b1);
    @(posedge pclk);
    ack(ch, 1'b0);
    idle(3);
    chk(req(ch), 32'h0);
    rd(atc_pkg::IDX_CONTROL, trig);
    wr(atc_pkg::IDX_INT_STATUS, 8'h02 << ch);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    wr(atc_pkg::IDX_CONTROL, 8'h00);
    idle(4);
    chk(req(ch), 32'h1);
    pin(ch, 1'b1);
    idle(6);
    chk(req(ch), 32'h0);
    rd(atc_pkg::IDX_CONTROL, 8'h00);
    $display("Request channel %0d test done", ch);
  endtask

  // Main sequence: reset, register map, overflow cases, request pins.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {cnt_pin, t_ack, a_ack, b_ack} = '0;
    pin_a = 1'b1;
    pin_b = 1'b1;
    presetn = 1'b0;
    seed = 32'h4071ba04;
    errors = 0;
    n_compared = 0;
    regs = '{atc_pkg::IDX_CONTROL, atc_pkg::IDX_COUNT_LOW, atc_pkg::IDX_RELOAD_LOW,
             atc_pkg::IDX_COUNT_HIGH, atc_pkg::IDX_RELOAD_HIGH, atc_pkg::IDX_INT_STATUS,
             atc_pkg::IDX_INT_MASK};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i])
      rd(regs[i], 8'h00);
    xfer(1'b0, 8'h89, 32'h0, 4'hf, 32'h0, 1'b1);
    xfer(1'b1, 8'h8e, 32'hff, 4'hf, 32'h0, 1'b1);
    xfer(1'b1, atc_pkg::IDX_RELOAD_HIGH, 32'hff, 4'he, 32'h0, 1'b0);
    rd(atc_pkg::IDX_RELOAD_HIGH, 8'h00);
    wr(atc_pkg::IDX_CONTROL, 8'h05);
    rd(atc_pkg::IDX_CONTROL, 8'h05);
    // Back to level mode, so that the pin moves of the overflow tests raise no edge status.
    wr(atc_pkg::IDX_CONTROL, 8'h00);
    rd(atc_pkg::IDX_CONTROL, 8'h00);
    $display("Register map test done");
    wr(atc_pkg::IDX_INT_MASK, 8'h01);
    ovf(8'h10, 1'b0, 1'b0, 1'b1);
    ovf(8'h00, 1'b1, 1'b0, 1'b0);
    ovf(8'h90, 1'b0, 1'b0, 1'b0);
    ovf(8'h90, 1'b1, 1'b0, 1'b1);
    ovf(8'h50, 1'b1, 1'b0, 1'b0);
    ovf(8'h50, 1'b1, 1'b1, 1'b1);
    wr(atc_pkg::IDX_INT_MASK, 8'h07);
    edges(0);
    edges(1);
    chk(exp_q.size(), 32'h0);
    complete_run();
  end
endmodule

`default_nettype wire
